/* rssp_cfg.svh */
// constants for the reset strap and status pin block
// assumes every includer relies on the guard against double inclusion
`ifndef RSSP_CFG_SVH
`define RSSP_CFG_SVH
`define RSSP_NUM_PORTS      4
`define RSSP_STRAP_WIDTH    3
`define RSSP_IDX_SERIAL     0
`define RSSP_IDX_PWRSUP     1
`define RSSP_IDX_POL        2
`define RSSP_STRAP_RST      3'h0
`define RSSP_SETTLE_CYCLES  4'h3
`endif

/* rssp_pkg.sv */
// types for the reset strap and status pin block
// assumes rssp_cfg.svh is on the include path
`include "rssp_cfg.svh"
package rssp_pkg;
    typedef enum logic [2:0] {
        RSSP_ST_SETTLE = 3'b001,
        RSSP_ST_SAMPLE = 3'b010,
        RSSP_ST_RUN    = 3'b100
    } rssp_state_t;
    typedef logic [`RSSP_NUM_PORTS-1:0] rssp_port_vec_t;
endpackage : rssp_pkg

/* rssp_strap_hold.sv */
// holds strap values captured once, on the capture_en pulse after reset release
// assumes capture_en pulses once per reset
`timescale 1ns/1ns
`include "rssp_cfg.svh"
module rssp_strap_hold (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        capture_en,
    input  wire logic [2:0]  strap_in,
    output logic      [2:0]  strap_q
);
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            strap_q <= `RSSP_STRAP_RST;
        else if (capture_en)
            strap_q <= strap_in;
    end
endmodule : rssp_strap_hold

/* rssp_top.sv */
// strap capture, serial pin routing, power control and status outputs
// assumes strap pins are pulled to level while reset is asserted
// Function
// - serial strap low: data pin is the bidirectional smbus data line.
// - serial strap sampled a few cycles after release; high i2c controller, low smbus target.
// - with status enabled, serial pin drives high while link suspended.
// - power strap low enables power switching and overcurrent; high disables both.
// - with switching, per-port power control and charge enable outputs driven.
// - in smbus mode, power strap level sets smbus target address bit 1.
// - with status enabled, power pin drives high when superspeed connected.
// - polarity strap low gives active-low power control, high active-high.
// - serial strap high: clock and data pins drive an external i2c eeprom.
// - serial strap low: clock pin is smbus clock from external host.
`timescale 1ns/1ns
`include "rssp_cfg.svh"
module rssp_top
    import rssp_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     serial_mode_pin_i,
    input  wire logic                     power_switch_pin_i,
    input  wire logic                     power_ctl_polarity_pin_i,
    output logic                          serial_mode_pin_o,
    output logic                          serial_mode_pin_oe,
    output logic                          power_switch_pin_o,
    output logic                          power_switch_pin_oe,
    output logic                          power_ctl_polarity_pin_oe,
    input  wire logic                     status_output_enable,
    input  wire logic                     ss_suspended,
    input  wire logic                     ss_connected,
    input  wire rssp_pkg::rssp_port_vec_t port_power_req,
    input  wire rssp_pkg::rssp_port_vec_t charge_req,
    input  wire rssp_pkg::rssp_port_vec_t overcurrent_n_i,
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    input  wire logic                     ctl_scl_o,
    input  wire logic                     ctl_scl_oe,
    input  wire logic                     ctl_sda_o,
    input  wire logic                     ctl_sda_oe,
    input  wire logic                     tgt_sda_o,
    input  wire logic                     tgt_sda_oe,
    output logic                          scl_o,
    output logic                          scl_oe,
    output logic                          sda_o,
    output logic                          sda_oe,
    output logic                          tgt_scl_q,
    output logic                          tgt_sda_q,
    output logic                          ctl_scl_in_q,
    output logic                          ctl_sda_in_q,
    output logic                          straps_valid,
    output logic                          i2c_controller_mode,
    output logic                          smbus_target_mode,
    output logic                          power_switch_supported,
    output logic                          smbus_addr_bit1_strap,
    output logic                          power_ctl_active_high,
    output rssp_pkg::rssp_port_vec_t      port_power_ctl_out,
    output rssp_pkg::rssp_port_vec_t      charge_enable_out,
    output rssp_pkg::rssp_port_vec_t      overcurrent_flag
);
    import rssp_pkg::*;

    rssp_state_t state_q;
    logic [3:0]  settle_q;
    logic        capture;
    logic [2:0]  strap_in;
    logic [2:0]  strap_q;

    // run-state decode shared by the strap, status and serial pin stages; the per-port stage does not use it
    function automatic logic is_run(input rssp_state_t st);
        return (st == RSSP_ST_RUN);
    endfunction : is_run

    // straps sampled a few cycles after release so pins have settled
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q  <= RSSP_ST_SETTLE;
            settle_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                RSSP_ST_SETTLE:
                begin
                    settle_q <= settle_q + 4'h1;
                    if (settle_q == `RSSP_SETTLE_CYCLES)
                        state_q <= RSSP_ST_SAMPLE;
                end
                RSSP_ST_SAMPLE: state_q <= RSSP_ST_RUN;
                RSSP_ST_RUN:    state_q <= RSSP_ST_RUN;
                default:        state_q <= RSSP_ST_SETTLE;
            endcase
        end
    end

    assign capture = (state_q == RSSP_ST_SAMPLE);
    assign strap_in = {power_ctl_polarity_pin_i, power_switch_pin_i, serial_mode_pin_i};

    rssp_strap_hold u_hold (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .capture_en (capture),
        .strap_in   (strap_in),
        .strap_q    (strap_q)
    );

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            straps_valid           <= 1'b0;
            i2c_controller_mode    <= 1'b0;
            smbus_target_mode      <= 1'b0;
            power_switch_supported <= 1'b0;
            smbus_addr_bit1_strap  <= 1'b0;
            power_ctl_active_high  <= 1'b0;
        end
        else
        begin
            straps_valid           <= is_run(state_q);
            i2c_controller_mode    <= is_run(state_q) &&  strap_q[`RSSP_IDX_SERIAL];
            smbus_target_mode      <= is_run(state_q) && !strap_q[`RSSP_IDX_SERIAL];
            power_switch_supported <= is_run(state_q) && !strap_q[`RSSP_IDX_PWRSUP];
            smbus_addr_bit1_strap  <= is_run(state_q) && !strap_q[`RSSP_IDX_SERIAL]
                                      && strap_q[`RSSP_IDX_PWRSUP];
            power_ctl_active_high  <= strap_q[`RSSP_IDX_POL];
        end
    end

    // status outputs only after straps are latched
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_mode_pin_o         <= 1'b0;
            serial_mode_pin_oe        <= 1'b0;
            power_switch_pin_o        <= 1'b0;
            power_switch_pin_oe       <= 1'b0;
            power_ctl_polarity_pin_oe <= 1'b0;
        end
        else
        begin
            serial_mode_pin_oe        <= is_run(state_q) && status_output_enable;
            serial_mode_pin_o         <= ss_suspended;
            power_switch_pin_oe       <= is_run(state_q) && status_output_enable;
            power_switch_pin_o        <= ss_connected;
            power_ctl_polarity_pin_oe <= 1'b0;
        end
    end

    // serial pins: controller drives eeprom, or target answers an smbus host
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_o        <= 1'b0;
            scl_oe       <= 1'b0;
            sda_o        <= 1'b0;
            sda_oe       <= 1'b0;
            tgt_scl_q    <= 1'b1;
            tgt_sda_q    <= 1'b1;
            ctl_scl_in_q <= 1'b1;
            ctl_sda_in_q <= 1'b1;
        end
        else if (!is_run(state_q))
        begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (strap_q[`RSSP_IDX_SERIAL])
        begin
            scl_o        <= ctl_scl_o;
            scl_oe       <= ctl_scl_oe;
            sda_o        <= ctl_sda_o;
            sda_oe       <= ctl_sda_oe;
            ctl_scl_in_q <= scl_i;
            ctl_sda_in_q <= sda_i;
            tgt_scl_q    <= 1'b1;
            tgt_sda_q    <= 1'b1;
        end
        else
        begin
            scl_o        <= 1'b0;
            scl_oe       <= 1'b0;
            tgt_scl_q    <= scl_i;
            sda_o        <= tgt_sda_o;
            sda_oe       <= tgt_sda_oe;
            tgt_sda_q    <= sda_i;
            ctl_scl_in_q <= 1'b1;
            ctl_sda_in_q <= 1'b1;
        end
    end

    // per-port power and charge; idle ports sit at the inactive level once polarity is latched; power control is low in reset, high until then
    genvar p;
    generate
        for (p = 0; p < `RSSP_NUM_PORTS; p = p + 1)
        begin : g_port
            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    port_power_ctl_out[p] <= 1'b0;
                    charge_enable_out[p]  <= 1'b0;
                    overcurrent_flag[p]   <= 1'b0;
                end
                else
                begin
                    // xnor with the latched polarity gives the physical pin level
                    port_power_ctl_out[p] <= (power_switch_supported && port_power_req[p])
                                             ~^ power_ctl_active_high;
                    charge_enable_out[p]  <= power_switch_supported && charge_req[p];
                    overcurrent_flag[p]   <= power_switch_supported && !overcurrent_n_i[p];
                end
            end
        end
    endgenerate
endmodule : rssp_top

/* rssp_assertions.sv */
// concurrent checks on the strap capture and status pin block
// assumes a bind into rssp_top; sees only its ports
`timescale 1ns/1ns
module rssp_chk
    import rssp_pkg::*;
(
    input wire logic                     core_clk,
    input wire logic                     rst_n,
    input wire logic                     straps_valid,
    input wire logic                     i2c_controller_mode,
    input wire logic                     smbus_target_mode,
    input wire logic                     power_switch_supported,
    input wire logic                     smbus_addr_bit1_strap,
    input wire logic                     power_ctl_active_high,
    input wire logic                     status_output_enable,
    input wire logic                     ss_suspended,
    input wire logic                     ss_connected,
    input wire logic                     serial_mode_pin_o,
    input wire logic                     serial_mode_pin_oe,
    input wire logic                     power_switch_pin_o,
    input wire logic                     power_switch_pin_oe,
    input wire logic                     sda_oe,
    input wire logic                     tgt_sda_oe,
    input wire logic                     ctl_sda_oe,
    input wire logic                     scl_oe,
    input wire logic                     ctl_scl_oe,
    input wire rssp_pkg::rssp_port_vec_t port_power_req,
    input wire rssp_pkg::rssp_port_vec_t charge_req,
    input wire rssp_pkg::rssp_port_vec_t overcurrent_n_i,
    input wire rssp_pkg::rssp_port_vec_t port_power_ctl_out,
    input wire rssp_pkg::rssp_port_vec_t charge_enable_out,
    input wire rssp_pkg::rssp_port_vec_t overcurrent_flag
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [3:0] sup;
    assign sup = {4{power_switch_supported}};
    sequence s_run;
        straps_valid ##1 straps_valid;
    endsequence
    sequence s_stat;
        s_run ##0 $past(status_output_enable);
    endsequence
    strap_hold_a: assert property (s_run |-> $stable({i2c_controller_mode,
        power_switch_supported, smbus_addr_bit1_strap, power_ctl_active_high}))
        else $error("strap outputs changed");
    pwr_ctl_a: assert property (s_run |-> port_power_ctl_out ==
        ({4{power_ctl_active_high}} ~^ (sup & $past(port_power_req))))
        else $error("power control level wrong");
    charge_en_a: assert property (s_run |-> charge_enable_out == (sup & $past(charge_req)))
        else $error("charge enable wrong");
    ocur_flag_a: assert property (s_run |-> overcurrent_flag == (sup & ~$past(overcurrent_n_i)))
        else $error("overcurrent flag wrong");
    suspend_st_a: assert property (s_stat |-> serial_mode_pin_oe &&
        serial_mode_pin_o == $past(ss_suspended)) else $error("suspend status wrong");
    connect_st_a: assert property (s_stat |-> power_switch_pin_oe &&
        power_switch_pin_o == $past(ss_connected)) else $error("connect status wrong");
    status_quiet_a: assert property (!$past(status_output_enable) |->
        !serial_mode_pin_oe && !power_switch_pin_oe) else $error("status pin driven");
    pin_route_a: assert property (s_run |-> (smbus_target_mode ?
        (sda_oe == $past(tgt_sda_oe) && !scl_oe) :
        (sda_oe == $past(ctl_sda_oe) && scl_oe == $past(ctl_scl_oe))))
        else $error("serial pin routing wrong");
    mode_excl_a: assert property (straps_valid |-> i2c_controller_mode ^ smbus_target_mode)
        else $error("serial modes not exclusive");
endmodule : rssp_chk
bind rssp_top rssp_chk u_chk (.*);

/* rssp_board.sv */
// board strap resistors on the shared strap and status pins
// assumes oe high means the block drives the pin
`timescale 1ns/1ns
module rssp_board (
    input  wire logic [2:0] strap,
    input  wire logic       ser_o,
    input  wire logic       ser_oe,
    input  wire logic       pwr_o,
    input  wire logic       pwr_oe,
    output logic            ser_pin,
    output logic            pwr_pin,
    output logic            pol_pin
);
    assign ser_pin = ser_oe ? ser_o : strap[0];
    assign pwr_pin = pwr_oe ? pwr_o : strap[1];
    assign pol_pin = strap[2];
endmodule : rssp_board

/* reset_strap_status_pins_tb_top.sv */
// self-checking bench for the strap capture and status pin block
// assumes the checker binds itself from its own file
`timescale 1ns/1ns
module reset_strap_status_pins_tb_top;
    import rssp_pkg::*;
    logic core_clk = 1'b0, rst_n = 1'b0;
    logic [2:0] strap = 3'h0, st;
    logic [22:0] cv = 23'h0;
    logic [31:0] r;
    integer seed = 24669, error_cnt = 0, tests_run = 0, cyc = 0;
    logic sm_i, pw_i, pl_i, s_o, s_oe, p_o, p_oe, vld, i2c_m, smb_m, sup_o, addr1, pol_o;
    rssp_port_vec_t pctl, chg, ocf;
    wire [3:0] pd, po;
    wire pl_oe;
    always #5 core_clk = ~core_clk;
    rssp_board board (.strap(strap), .ser_o(s_o), .ser_oe(s_oe), .pwr_o(p_o), .pwr_oe(p_oe),
        .ser_pin(sm_i), .pwr_pin(pw_i), .pol_pin(pl_i));
    rssp_top dut (.core_clk(core_clk), .rst_n(rst_n), .serial_mode_pin_i(sm_i),
        .power_switch_pin_i(pw_i), .power_ctl_polarity_pin_i(pl_i), .serial_mode_pin_o(s_o),
        .serial_mode_pin_oe(s_oe), .power_switch_pin_o(p_o), .power_switch_pin_oe(p_oe),
        .power_ctl_polarity_pin_oe(pl_oe), .status_output_enable(cv[22]), .ss_suspended(cv[21]),
        .ss_connected(cv[20]), .port_power_req(cv[19:16]), .charge_req(cv[15:12]),
        .overcurrent_n_i(cv[11:8]), .scl_i(cv[0]), .sda_i(cv[1]), .ctl_scl_o(cv[2]),
        .ctl_scl_oe(cv[3]), .ctl_sda_o(cv[4]), .ctl_sda_oe(cv[5]), .tgt_sda_o(cv[6]),
        .tgt_sda_oe(cv[7]), .scl_o(pd[0]), .scl_oe(pd[1]), .sda_o(pd[2]), .sda_oe(pd[3]),
        .tgt_scl_q(po[0]), .tgt_sda_q(po[1]), .ctl_scl_in_q(po[2]), .ctl_sda_in_q(po[3]),
        .straps_valid(vld),
        .i2c_controller_mode(i2c_m), .smbus_target_mode(smb_m), .power_switch_supported(sup_o),
        .smbus_addr_bit1_strap(addr1), .power_ctl_active_high(pol_o),
        .port_power_ctl_out(pctl), .charge_enable_out(chg), .overcurrent_flag(ocf));
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : print_verdict
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    initial
    begin
        for (int s = 0; s < 8; s++)
        begin
            st = s[2:0];
            strap = st;
            rst_n = 1'b0;
            repeat (10) @(negedge core_clk);
            rst_n = 1'b1;
            repeat (12) @(negedge core_clk);
            // pins now change; captured straps must not follow
            strap = ~st;
            for (int k = 0; k < 40; k++)
            begin
                r = $random(seed);
                // charging is only requested when switching is strapped supported
                cv = {r[22:16], r[15:12] & {4{!st[1]}}, r[11:0]};
                @(negedge core_clk);
                chk({1'b0, vld, i2c_m, smb_m}, {2'b01, st[0], !st[0]});
                chk({1'b0, sup_o, addr1, pol_o},
                    {1'b0, !st[1], !st[0] & st[1], st[2]});
                chk(pctl, {4{st[2]}} ~^ ({4{!st[1]}} & cv[19:16]));
                chk(chg, {4{!st[1]}} & cv[15:12]);
                chk(ocf, {4{!st[1]}} & ~cv[11:8]);
                chk({1'b0, pl_oe, s_oe, p_oe}, {2'b00, {2{cv[22]}}});
                if (cv[22])
                    chk({2'b00, s_o, p_o}, {2'b00, cv[21:20]});
                chk(pd, st[0] ? cv[5:2] : {cv[7:6], 2'b00});
                chk(po, st[0] ? {cv[1:0], 2'b11} : {2'b11, cv[1:0]});
            end
            $display("strap set %0d done", s);
        end
        print_verdict();
    end
endmodule : reset_strap_status_pins_tb_top
